// ===== inc/wdr_pkg.sv
// constants of the watchdog and regulator control block
package wdr_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_RCAUSE = 8'h04;
	localparam logic [7:0] OFS_PFLAG2 = 8'h08;
	localparam logic [7:0] OFS_ISTAT  = 8'h0c;
	localparam logic [7:0] OFS_ICLR   = 8'h10;
	localparam logic [7:0] OFS_IEN    = 8'h14;
	localparam logic [7:0] OFS_WSTAT  = 8'h18;
	// watchdog_control fields
	localparam int CTRL_SOFT_EN  = 0;
	localparam int CTRL_REGULATOR_SLEEP_LOWPOWER   = 7;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// reset_cause_flags fields
	localparam int RC_PRIO_EN    = 7;
	localparam int RC_TIMEOUT    = 3;
	localparam int RC_POWERDOWN  = 2;
	// peripheral_flag_reg_two field
	localparam int PF2_LOWV      = 2;
	// interrupt status fields
	localparam int IRQ_TIMEOUT   = 0;
	localparam int IRQ_LOWV      = 1;
	localparam int IRQ_BITS      = 2;
	// bus answers
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// timing
	localparam int MCLK_PERIOD_NS = 10;
	localparam int WDT_BASE_NS    = 4000000;
	localparam int WDT_BASE_CYC   = WDT_BASE_NS / MCLK_PERIOD_NS;
	localparam int PS_WIDTH       = 16;
endpackage : wdr_pkg

// ===== hdl/wdr_timer.sv
// watchdog base divider and postscaler with tap select
`timescale 1ns/100ps
module wdr_timer #(
	parameter int BASE_CYC = wdr_pkg::WDT_BASE_CYC,
	parameter int PSW      = wdr_pkg::PS_WIDTH
) (
	// clock and reset
	input  wire logic            mclk,
	input  wire logic            nrst,
	// control
	input  wire logic            run,
	input  wire logic            clear,
	input  wire logic [3:0]      sel,
	// state
	output logic                 expire_ff,
	output logic [PSW-1:0]       ps_count_ff
);
	logic [31:0]    base_cnt_ff;
	logic           tick;
	logic [PSW-1:0] mask;

	function automatic logic [PSW-1:0] tap_mask(input logic [3:0] s);
		tap_mask = (PSW'(1) << s) - PSW'(1);
	endfunction : tap_mask

	assign tick = run && !clear && (base_cnt_ff == 32'(BASE_CYC - 1));
	assign mask = tap_mask(sel);

	// base divider standing in for the rc oscillator period
	always_ff @(posedge mclk or negedge nrst) begin // [R1]
		if (!nrst) begin
			base_cnt_ff <= 32'h0;
		end else if (!run || clear || tick) begin // [R8] [R9]
			base_cnt_ff <= 32'h0;
		end else begin
			base_cnt_ff <= base_cnt_ff + 32'h1; // [R3]
		end
	end

	// postscaler: expire when the selected tap count is reached
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			ps_count_ff <= '0;
			expire_ff   <= 1'b0;
		end else begin
			expire_ff <= tick && ((ps_count_ff & mask) == mask); // [R5] [R6] [R7]
			if (!run || clear) begin
				ps_count_ff <= '0; // [R8] [R18]
			end else if (tick) begin
				ps_count_ff <= ((ps_count_ff & mask) == mask) ? '0 : ps_count_ff + PSW'(1); // [R4]
			end
		end
	end
endmodule : wdr_timer

// ===== hdl/wdr_top.sv
// watchdog timer with regulator sleep control and axi4-lite registers
// Operation
// [R1] watchdog counts from internal rc oscillator
// [R2] watchdog enabled turns the rc oscillator on
// [R3] base tick period is nominally 4 ms
// [R4] sixteen-bit postscaler extends the base tick
// [R5] period select picks the postscaler tap
// [R6] code zero is 1:1, each step doubles
// [R7] periods span 4 ms to 131.072 s
// [R8] sleep or clear instruction clears counters
// [R9] clock failure clears counter and postscaler
// [R10] control bit 0 is software enable
// [R11] config enable overrides the software enable
// [R12] control bit 7 selects regulator sleep low-power
// [R13] control bits 6..1 read zero, ignore writes
// [R14] low-voltage detect sets the low-voltage flag
// [R15] low-voltage detect clears regulator sleep bit
// [R16] low-voltage flag only with regulator strap on
// [R17] software may set sleep bit again
// [R18] count only while enabled, else held cleared
// [R19] expiry resets when running, wakes in sleep
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
module wdr_top #(
	parameter int BASE_CYC = wdr_pkg::WDT_BASE_CYC
) (
	// clock and reset
	input  wire logic        mclk,
	input  wire logic        nrst,
	// axi4-lite write
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	output logic [1:0]       s_bresp,
	// axi4-lite read
	input  wire logic        s_arvalid,
	output logic             s_arready,
	input  wire logic [7:0]  s_araddr,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	// core events, same clock
	input  wire logic        sleep_instr,
	input  wire logic        clear_watchdog_instr,
	input  wire logic        core_sleeping,
	input  wire logic        clock_fail,
	// pins and configuration straps
	input  wire logic        config_watchdog_enable,
	input  wire logic [3:0]  watchdog_period_select,
	input  wire logic        regulator_enable_strap,
	input  wire logic        low_voltage_detect,
	// outputs
	output logic             rc_osc_enable,
	output logic             wdt_reset,
	output logic             wdt_wake,
	output logic             regulator_lowpower,
	output logic             irq
);
	localparam int IRQ_W = wdr_pkg::IRQ_BITS;
	logic [1:0]  cfg_en_sy_ff, strap_sy_ff, lvd_sy_ff;
	logic [3:0]  sel_sy0_ff, sel_sy1_ff;
	logic        lvd_prev_ff;
	logic        soft_en_ff, regulator_sleep_lowpower_ff, prio_en_ff;
	logic        timeout_flag_ff, powerdown_flag_ff, lowv_flag_ff;
	logic [IRQ_W-1:0] istat_ff, ien_ff;
	logic [7:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic        wlane0_ff;
	logic        awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
	logic [1:0]  bresp_ff, rresp_ff;
	logic [31:0] rdata_ff;
	logic        rc_osc_ff, wdt_reset_ff, wdt_wake_ff, reglp_ff, irq_ff;
	logic        wdt_on, wdt_clear, expire, lvd_event, do_wr;
	logic [15:0] ps_count;

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == wdr_pkg::OFS_CTRL)  || (a == wdr_pkg::OFS_RCAUSE) || (a == wdr_pkg::OFS_PFLAG2) ||
		         (a == wdr_pkg::OFS_ISTAT) || (a == wdr_pkg::OFS_ICLR)   || (a == wdr_pkg::OFS_IEN) ||
		         (a == wdr_pkg::OFS_WSTAT);
	endfunction : mapped

	function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs);
		wr_hit = (a == ofs);
	endfunction : wr_hit

	// pin synchronisers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cfg_en_sy_ff <= 2'h0;
			strap_sy_ff  <= 2'h0;
			lvd_sy_ff    <= 2'h0;
			sel_sy0_ff   <= 4'h0;
			sel_sy1_ff   <= 4'h0;
			lvd_prev_ff  <= 1'b0;
		end else begin
			cfg_en_sy_ff <= {cfg_en_sy_ff[0], config_watchdog_enable};
			strap_sy_ff  <= {strap_sy_ff[0], regulator_enable_strap};
			lvd_sy_ff    <= {lvd_sy_ff[0], low_voltage_detect};
			sel_sy0_ff   <= watchdog_period_select;
			sel_sy1_ff   <= sel_sy0_ff;
			lvd_prev_ff  <= lvd_sy_ff[1];
		end
	end

	assign wdt_on    = cfg_en_sy_ff[1] || soft_en_ff; // [R11] [R18]
	assign wdt_clear = sleep_instr || clear_watchdog_instr || clock_fail; // [R8] [R9]
	assign lvd_event = lvd_sy_ff[1] && !lvd_prev_ff && strap_sy_ff[1]; // [R16]
	assign do_wr     = !awready_ff && !wready_ff && !bvalid_ff;

	wdr_timer #(
		.BASE_CYC (BASE_CYC),
		.PSW      (wdr_pkg::PS_WIDTH)
	) u_timer (
		.mclk        (mclk),
		.nrst        (nrst),
		.run         (wdt_on),
		.clear       (wdt_clear),
		.sel         (sel_sy1_ff),
		.expire_ff   (expire),
		.ps_count_ff (ps_count)
	);

	// axi write channel handshakes
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
			bvalid_ff  <= 1'b0;
			bresp_ff   <= wdr_pkg::RESP_OKAY;
			awaddr_ff  <= 8'h0;
			wdata_ff   <= 32'h0;
			wlane0_ff  <= 1'b0;
		end else begin
			if (s_awvalid && awready_ff) begin
				awready_ff <= 1'b0;
				awaddr_ff  <= s_awaddr;
			end
			if (s_wvalid && wready_ff) begin
				wready_ff <= 1'b0;
				wdata_ff  <= s_wdata;
				wlane0_ff <= s_wstrb[0];
			end
			if (do_wr) begin
				bvalid_ff <= 1'b1;
				bresp_ff  <= mapped(awaddr_ff) ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
			end
			if (bvalid_ff && s_bready) begin
				bvalid_ff  <= 1'b0;
				awready_ff <= 1'b1;
				wready_ff  <= 1'b1;
			end
		end
	end

	// axi read channel
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			arready_ff <= 1'b1;
			rvalid_ff  <= 1'b0;
			rdata_ff   <= 32'h0;
			rresp_ff   <= wdr_pkg::RESP_OKAY;
		end else if (s_arvalid && arready_ff) begin
			arready_ff <= 1'b0;
			rvalid_ff  <= 1'b1;
			rresp_ff   <= mapped(s_araddr) ? wdr_pkg::RESP_OKAY : wdr_pkg::RESP_SLVERR;
			unique case (s_araddr)
				wdr_pkg::OFS_CTRL:   rdata_ff <= {24'h0, regulator_sleep_lowpower_ff, 6'h00, soft_en_ff}; // [R13]
				wdr_pkg::OFS_RCAUSE: rdata_ff <= {24'h0, prio_en_ff, 3'h0, timeout_flag_ff, powerdown_flag_ff, 2'h0};
				wdr_pkg::OFS_PFLAG2: rdata_ff <= {29'h0, lowv_flag_ff, 2'h0};
				wdr_pkg::OFS_ISTAT:  rdata_ff <= {30'h0, istat_ff};
				wdr_pkg::OFS_IEN:    rdata_ff <= {30'h0, ien_ff};
				wdr_pkg::OFS_WSTAT:  rdata_ff <= {15'h0, wdt_on, ps_count};
				default:             rdata_ff <= 32'h0;
			endcase
		end else if (rvalid_ff && s_rready) begin
			rvalid_ff  <= 1'b0;
			arready_ff <= 1'b1;
		end
	end

	// watchdog_control: software enable and regulator sleep bit
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			soft_en_ff <= wdr_pkg::CTRL_RESET[wdr_pkg::CTRL_SOFT_EN];
			regulator_sleep_lowpower_ff  <= wdr_pkg::CTRL_RESET[wdr_pkg::CTRL_REGULATOR_SLEEP_LOWPOWER];
		end else begin
			if (do_wr && wlane0_ff && wr_hit(awaddr_ff, wdr_pkg::OFS_CTRL)) begin
				soft_en_ff <= wdata_ff[wdr_pkg::CTRL_SOFT_EN]; // [R10]
				regulator_sleep_lowpower_ff  <= wdata_ff[wdr_pkg::CTRL_REGULATOR_SLEEP_LOWPOWER];  // [R17]
			end
			if (lvd_event) begin
				regulator_sleep_lowpower_ff <= 1'b0; // [R15]
			end
		end
	end

	// reset cause and low-voltage flags, hardware set wins over clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			prio_en_ff        <= 1'b0;
			timeout_flag_ff   <= 1'b0;
			powerdown_flag_ff <= 1'b0;
			lowv_flag_ff      <= 1'b0;
		end else begin
			if (do_wr && wlane0_ff && wr_hit(awaddr_ff, wdr_pkg::OFS_RCAUSE)) begin
				prio_en_ff <= wdata_ff[wdr_pkg::RC_PRIO_EN];
				if (wdata_ff[wdr_pkg::RC_TIMEOUT]) begin
					timeout_flag_ff <= 1'b0;
				end
				if (wdata_ff[wdr_pkg::RC_POWERDOWN]) begin
					powerdown_flag_ff <= 1'b0;
				end
			end
			if (do_wr && wlane0_ff && wr_hit(awaddr_ff, wdr_pkg::OFS_PFLAG2) && !wdata_ff[wdr_pkg::PF2_LOWV]) begin
				lowv_flag_ff <= 1'b0;
			end
			if (expire) begin
				timeout_flag_ff <= 1'b1;
			end
			if (sleep_instr) begin
				powerdown_flag_ff <= 1'b1;
			end
			if (lvd_event) begin
				lowv_flag_ff <= 1'b1; // [R14]
			end
		end
	end

	// interrupt status, enable and clear
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			istat_ff <= '0;
			ien_ff   <= '0;
		end else begin
			if (do_wr && wlane0_ff && wr_hit(awaddr_ff, wdr_pkg::OFS_IEN)) begin
				ien_ff <= wdata_ff[IRQ_W-1:0];
			end
			istat_ff <= (istat_ff & ~((do_wr && wlane0_ff && wr_hit(awaddr_ff, wdr_pkg::OFS_ICLR)) ?
			            wdata_ff[IRQ_W-1:0] : '0)) | {lvd_event, expire};
		end
	end

	// outputs
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rc_osc_ff    <= 1'b0;
			wdt_reset_ff <= 1'b0;
			wdt_wake_ff  <= 1'b0;
			reglp_ff     <= 1'b0;
			irq_ff       <= 1'b0;
		end else begin
			rc_osc_ff    <= wdt_on; // [R2]
			wdt_reset_ff <= expire && !core_sleeping; // [R19]
			wdt_wake_ff  <= expire && core_sleeping;  // [R19]
			reglp_ff     <= regulator_sleep_lowpower_ff && core_sleeping && strap_sy_ff[1]; // [R12]
			irq_ff       <= |(istat_ff & ien_ff);
		end
	end

	assign s_awready          = awready_ff;
	assign s_wready           = wready_ff;
	assign s_bvalid           = bvalid_ff;
	assign s_bresp            = bresp_ff;
	assign s_arready          = arready_ff;
	assign s_rvalid           = rvalid_ff;
	assign s_rdata            = rdata_ff;
	assign s_rresp            = rresp_ff;
	assign rc_osc_enable      = rc_osc_ff;
	assign wdt_reset          = wdt_reset_ff;
	assign wdt_wake           = wdt_wake_ff;
	assign regulator_lowpower = reglp_ff;
	assign irq                = irq_ff;

	// checks
	sequence ctrl_read_s;
		s_arvalid && arready_ff && (s_araddr == wdr_pkg::OFS_CTRL);
	endsequence
	sequence lvd_seen_s;
		lvd_event ##1 1'b1;
	endsequence

	ctrl_rsvd_a: assert property (@(posedge mclk) disable iff (!nrst) // [R13]
		ctrl_read_s |=> rvalid_ff && (rdata_ff[6:1] == 6'h00))
		else $error("reserved control bits not zero");
	osc_follow_a: assert property (@(posedge mclk) disable iff (!nrst) // [R2]
		wdt_on |=> rc_osc_enable)
		else $error("rc oscillator off while watchdog on");
	cfg_override_a: assert property (@(posedge mclk) disable iff (!nrst) // [R11]
		(cfg_en_sy_ff[1] && !soft_en_ff) |=> rc_osc_enable)
		else $error("config enable did not force watchdog on");
	clr_counter_a: assert property (@(posedge mclk) disable iff (!nrst) // [R8]
		(sleep_instr || clear_watchdog_instr) |=> (ps_count == 16'h0000) && !expire)
		else $error("postscaler not cleared by instruction");
	fail_clear_a: assert property (@(posedge mclk) disable iff (!nrst) // [R9]
		clock_fail |=> ps_count == 16'h0000)
		else $error("postscaler not cleared by clock failure");
	off_hold_a: assert property (@(posedge mclk) disable iff (!nrst) // [R18]
		!wdt_on |=> (ps_count == 16'h0000) && !expire)
		else $error("watchdog counted while disabled");
	expire_reset_a: assert property (@(posedge mclk) disable iff (!nrst) // [R19]
		(expire && !core_sleeping) |=> wdt_reset && !wdt_wake)
		else $error("expiry while running gave no reset");
	expire_wake_a: assert property (@(posedge mclk) disable iff (!nrst) // [R19]
		(expire && core_sleeping) |=> wdt_wake && !wdt_reset)
		else $error("expiry in sleep gave no wake");
	lvd_flag_a: assert property (@(posedge mclk) disable iff (!nrst) // [R14]
		lvd_event |=> lowv_flag_ff)
		else $error("low-voltage flag not set");
	lvd_regulator_sleep_lowpower_a: assert property (@(posedge mclk) disable iff (!nrst) // [R15]
		lvd_seen_s |-> !regulator_sleep_lowpower_ff)
		else $error("regulator sleep bit not cleared");
	no_strap_a: assert property (@(posedge mclk) disable iff (!nrst) // [R16]
		(!strap_sy_ff[1] && !lowv_flag_ff) |=> !lowv_flag_ff)
		else $error("low-voltage flag set with regulator off");
	soft_en_a: assert property (@(posedge mclk) disable iff (!nrst) // [R10]
		(do_wr && wlane0_ff && (awaddr_ff == wdr_pkg::OFS_CTRL)) |=> soft_en_ff == $past(wdata_ff[0]))
		else $error("software enable not written");
endmodule : wdr_top

// ===== testbench/wdr_core_model.sv
// behavioural model of the core issuing sleep and clear instructions
`timescale 1ns/100ps
module wdr_core_model (
	// clock
	input  wire logic mclk,
	// instruction events
	output logic      sleep_instr,
	output logic      clear_watchdog_instr,
	output logic      core_sleeping
);
	initial begin
		sleep_instr          = 1'b0;
		clear_watchdog_instr = 1'b0;
		core_sleeping        = 1'b0;
	end
	// one-cycle clear instruction
	task automatic pulse_clear();
		@(posedge mclk);
		clear_watchdog_instr <= 1'b1;
		@(posedge mclk);
		clear_watchdog_instr <= 1'b0;
	endtask : pulse_clear
	// sleep instruction; core stays asleep until woken
	task automatic enter_sleep();
		@(posedge mclk);
		sleep_instr   <= 1'b1;
		core_sleeping <= 1'b1;
		@(posedge mclk);
		sleep_instr <= 1'b0;
	endtask : enter_sleep
	task automatic wake();
		@(posedge mclk);
		core_sleeping <= 1'b0;
	endtask : wake
endmodule : wdr_core_model

// ===== testbench/testbench.sv
// self-checking bench for the watchdog and regulator control block
`timescale 1ns/100ps
module testbench;
	localparam int BASE = 4;
	logic        mclk, nrst, s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic        s_arvalid, s_arready, s_rvalid, s_rready, clock_fail, config_watchdog_enable;
	logic        sleep_instr, clear_watchdog_instr, core_sleeping, regulator_enable_strap;
	logic        low_voltage_detect, rc_osc_enable, wdt_reset, wdt_wake, regulator_lowpower, irq;
	logic [7:0]  s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, d;
	logic [3:0]  s_wstrb, watchdog_period_select;
	logic [1:0]  s_bresp, s_rresp, r;
	int          miscompares, num_checks, cyc, rst_cnt, n;

	wdr_top #(.BASE_CYC(BASE)) wdr_top_i (
		.mclk                   (mclk),
		.nrst                   (nrst),
		.s_awvalid              (s_awvalid),
		.s_awready              (s_awready),
		.s_awaddr               (s_awaddr),
		.s_wvalid               (s_wvalid),
		.s_wready               (s_wready),
		.s_wdata                (s_wdata),
		.s_wstrb                (s_wstrb),
		.s_bvalid               (s_bvalid),
		.s_bready               (s_bready),
		.s_bresp                (s_bresp),
		.s_arvalid              (s_arvalid),
		.s_arready              (s_arready),
		.s_araddr               (s_araddr),
		.s_rvalid               (s_rvalid),
		.s_rready               (s_rready),
		.s_rdata                (s_rdata),
		.s_rresp                (s_rresp),
		.sleep_instr            (sleep_instr),
		.clear_watchdog_instr   (clear_watchdog_instr),
		.core_sleeping          (core_sleeping),
		.clock_fail             (clock_fail),
		.config_watchdog_enable (config_watchdog_enable),
		.watchdog_period_select (watchdog_period_select),
		.regulator_enable_strap (regulator_enable_strap),
		.low_voltage_detect     (low_voltage_detect),
		.rc_osc_enable          (rc_osc_enable),
		.wdt_reset              (wdt_reset),
		.wdt_wake               (wdt_wake),
		.regulator_lowpower     (regulator_lowpower),
		.irq                    (irq)
	);
	wdr_core_model wdr_core_model_i (
		.mclk                 (mclk),
		.sleep_instr          (sleep_instr),
		.clear_watchdog_instr (clear_watchdog_instr),
		.core_sleeping        (core_sleeping)
	);

	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// hang guard and reset pulse counter
	always @(posedge mclk) begin
		cyc++;
		if (wdt_reset === 1'b1) rst_cnt++;
		if (cyc == 30000) begin
			miscompares++;
			close_out();
		end
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		s_awvalid <= 1'b1;
		s_awaddr  <= a;
		s_wvalid  <= 1'b1;
		s_wdata   <= v;
		s_bready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (s_bvalid !== 1'b1);
		r = s_bresp;
		s_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		s_arvalid <= 1'b1;
		s_araddr  <= a;
		s_rready  <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_arready) s_arvalid <= 1'b0;
		end while (s_rvalid !== 1'b1);
		d = s_rdata;
		r = s_rresp;
		s_rready <= 1'b0;
	endtask : rd

	// flush the timer by a clock failure while the period select settles
	task automatic arm(input int s);
		@(posedge mclk);
		clock_fail             <= 1'b1;
		watchdog_period_select <= 4'(s);
		repeat (4) @(posedge mclk);
		clock_fail <= 1'b0;
	endtask : arm

	task automatic count_to();
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (wdt_reset !== 1'b1 && wdt_wake !== 1'b1);
	endtask : count_to

	task automatic t_regs();
		wr(wdr_pkg::OFS_CTRL, 32'h0000_00ff);
		chk(r, wdr_pkg::RESP_OKAY, "ctrl write resp");
		rd(wdr_pkg::OFS_CTRL);
		chk(d, 32'h0000_0081, "ctrl readback");
		// lane 0 strobe low: the write must be ignored
		s_wstrb <= 4'he;
		wr(wdr_pkg::OFS_CTRL, 32'h0000_0000);
		s_wstrb <= 4'hf;
		rd(wdr_pkg::OFS_CTRL);
		chk(d, 32'h0000_0081, "masked write kept");
		repeat (2) @(posedge mclk);
		chk(rc_osc_enable, 1'b1, "osc on");
		wr(8'h1c, 32'h0000_00ff);
		chk(r, wdr_pkg::RESP_SLVERR, "unmapped write");
		rd(8'h1c);
		chk(d, 32'h0, "unmapped read data");
		chk(r, wdr_pkg::RESP_SLVERR, "unmapped read resp");
		$display("regs done");
	endtask : t_regs

	task automatic t_timer();
		int sels[7] = '{0, 1, 2, 3, 4, 5, 9};
		wr(wdr_pkg::OFS_CTRL, 32'h0000_0001);
		foreach (sels[i]) begin
			arm(sels[i]);
			count_to();
			chk(n >= BASE * (1 << sels[i]) - 1 && n <= BASE * (1 << sels[i]) + 3, 1'b1, "period");
			chk(wdt_reset, 1'b1, "reset pulse");
		end
		rd(wdr_pkg::OFS_RCAUSE);
		chk(d[3], 1'b1, "timeout cause");
		$display("timer done");
	endtask : t_timer

	task automatic t_sleep();
		regulator_enable_strap <= 1'b1;
		wr(wdr_pkg::OFS_CTRL, 32'h0000_0081);
		arm(2);
		wdr_core_model_i.enter_sleep();
		repeat (2) @(posedge mclk);
		chk(regulator_lowpower, 1'b1, "lowpower in sleep");
		count_to();
		chk({wdt_wake, wdt_reset}, 2'b10, "wake not reset");
		chk(n >= 4 * BASE - 3 && n <= 4 * BASE + 3, 1'b1, "sleep period");
		wdr_core_model_i.wake();
		repeat (2) @(posedge mclk);
		chk(regulator_lowpower, 1'b0, "lowpower awake");
		$display("sleep done");
	endtask : t_sleep

	task automatic t_keep(input bit use_fail);
		int base;
		arm(1);
		base = rst_cnt;
		repeat (8) begin
			repeat (3) @(posedge mclk);
			if (use_fail) begin
				clock_fail <= 1'b1;
				@(posedge mclk);
				clock_fail <= 1'b0;
			end else wdr_core_model_i.pulse_clear();
		end
		chk(rst_cnt - base, 0, "cleared timer fired");
		count_to();
		chk(n <= 12, 1'b1, "timer still armed");
		$display("keep alive done");
	endtask : t_keep

	task automatic t_enable();
		int base;
		wr(wdr_pkg::OFS_CTRL, 32'h0);
		arm(0);
		base = rst_cnt;
		repeat (40) @(posedge mclk);
		chk(rst_cnt - base, 0, "disabled fired");
		chk(rc_osc_enable, 1'b0, "osc off");
		config_watchdog_enable <= 1'b1;
		count_to();
		chk(n <= 10, 1'b1, "config enable");
		chk(rc_osc_enable, 1'b1, "osc on by config");
		config_watchdog_enable <= 1'b0;
		$display("enable done");
	endtask : t_enable

	task automatic t_lvd(input logic strap);
		regulator_enable_strap <= strap;
		wr(wdr_pkg::OFS_IEN, 32'h2);
		wr(wdr_pkg::OFS_CTRL, 32'h80);
		low_voltage_detect <= 1'b1;
		repeat (6) @(posedge mclk);
		low_voltage_detect <= 1'b0;
		chk(irq, strap, "lvd irq");
		rd(wdr_pkg::OFS_PFLAG2);
		chk(d[2], strap, "lvd flag");
		rd(wdr_pkg::OFS_CTRL);
		chk(d, strap ? 32'h0 : 32'h80, "regulator_sleep_lowpower after lvd");
		wr(wdr_pkg::OFS_ICLR, 32'h2);
		wr(wdr_pkg::OFS_PFLAG2, 32'h0);
		@(posedge mclk);
		chk(irq, 1'b0, "irq cleared");
		wr(wdr_pkg::OFS_CTRL, 32'h80);
		rd(wdr_pkg::OFS_CTRL);
		chk(d, 32'h80, "regulator_sleep_lowpower set again");
		$display("lvd done");
	endtask : t_lvd

	initial begin
		{nrst, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready, clock_fail} = '0;
		{config_watchdog_enable, regulator_enable_strap, low_voltage_detect} = '0;
		{s_awaddr, s_araddr, s_wdata, watchdog_period_select} = '0;
		s_wstrb = 4'hf;
		repeat (3) @(posedge mclk);
		nrst <= 1'b1;
		rd(wdr_pkg::OFS_CTRL);
		chk(d, 32'h0, "ctrl reset");
		t_regs();
		t_timer();
		t_sleep();
		t_keep(1'b0);
		t_keep(1'b1);
		t_enable();
		t_lvd(1'b0);
		t_lvd(1'b1);
		close_out();
	end
endmodule : testbench
